// ===== design/dram_host_consts.svh
// timing and geometry constants for the dram host controller
`ifndef DRAM_HOST_CONSTS_SVH
`define DRAM_HOST_CONSTS_SVH
`define ADDR_W 10
`define DATA_W 32
`define LANES 4
`define CNT_W 14
`define T_CLK_NS 8
`define T_RP_NS 70
`define T_RAS_NS 100
`define T_RCD_NS 25
`define T_RAH_NS 15
`define T_WCH_NS 20
`define T_WP_NS 20
`define T_DH_NS 20
`define T_CAC_NS 25
`define T_PC_NS 55
`define T_CP_NS 10
`define T_ACP_NS 50
`define T_RHCP_NS 50
`define T_CSR_NS 10
`define T_CHR_NS 10
`define T_RPC_NS 10
`define T_PAGE_MAX_NS 100000
`define T_INIT_US 100
`define T_REF_MS 16
`define REF_ROWS 1024
`define INIT_CYCLES 8
`define NS_PER_US 1000
`define NS_PER_MS 1000000
`define CYC_UP(t) (((t) + `T_CLK_NS - 1) / `T_CLK_NS)
`define CYC_DN(t) ((t) / `T_CLK_NS)
`define AT_LEAST1(x) (((x) < 1) ? 1 : (x))
`define MAX2(a, b) (((a) > (b)) ? (a) : (b))
`endif

// ===== design/dram_host_pkg.sv
// types shared by the dram host controller
`include "dram_host_consts.svh"
package dram_host_pkg;
  typedef enum logic [9:0] {
    ST_IDLE    = 10'h001,
    ST_INIT    = 10'h002,
    ST_ROR     = 10'h004,
    ST_PRECH   = 10'h008,
    ST_ROW     = 10'h010,
    ST_COL     = 10'h020,
    ST_CPRE    = 10'h040,
    ST_RHOLD   = 10'h080,
    ST_CBR_SET = 10'h100,
    ST_CBR_RAS = 10'h200
  } state_t;
  typedef struct packed {
    logic               write;
    logic [`ADDR_W-1:0] row;
    logic [`ADDR_W-1:0] col;
    logic [`LANES-1:0]  be;
    logic [`DATA_W-1:0] wdata;
  } req_t;
  typedef struct packed {
    logic               ras_n;
    logic [`LANES-1:0]  cas_n;
    logic               we_n;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] dq_out;
    logic               dq_oe;
  } pins_t;
endpackage : dram_host_pkg

// ===== design/dram_host.sv
// host controller driving an asynchronous page mode dram module
`timescale 1ns/1ns
`default_nettype none
`include "dram_host_consts.svh"
// Functional notes
// RULE1: after power-up wait at least 100 us, then give eight row-strobe cycles before any access.
// RULE2: issue 1,024 refresh cycles per refresh period so every row is refreshed once.
// RULE3: write strobe goes low no later than the column strobe falls, giving an early write.
// RULE4: write data is valid when the column strobe falls and held at least 20 ns after.
// RULE5: write strobe stays low 20 ns after the column strobe falls, pulse at least 20 ns.
// RULE6: for column-before-row refresh the column strobe leads the row strobe by 10 ns and holds 10 ns.
// RULE7: column strobe stays high 10 ns after the row strobe rises before a column-before-row refresh.
// RULE8: page mode column cycles are spaced at least 55 ns.
// RULE9: between page cycles the column strobe stays high at least 10 ns.
// RULE10: row strobe is low at most 100000 ns during a page burst.
// RULE11: read data is taken no sooner than the longest of address, column and precharge access times.
// RULE12: row strobe stays low at least 50 ns after the last column precharge begins.
// RULE13: beyond the row-to-column limits access time follows column or address access alone.
// RULE14: the 1,024 refreshes complete within 16 ms.
// RULE15: refresh is row-only with a supplied address or column-before-row with an internal address.
// RULE16: strobe edges are sequenced by a state machine with minima rounded up and maxima down.
// RULE17: in an early write the module floats its outputs so the host drives the data lines.
module dram_host #(
  parameter int INIT_CYC     = (`T_INIT_US * `NS_PER_US) / `T_CLK_NS,
  parameter int PAGE_MAX_CYC = `CYC_DN(`T_PAGE_MAX_NS)
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // user request side
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire dram_host_pkg::req_t   req,
  output logic                       rsp_valid,
  output logic [`DATA_W-1:0]         rsp_data,
  output logic                       init_done,
  // dram pins
  output dram_host_pkg::pins_t       pins,
  input  wire logic [`DATA_W-1:0]    dq_in
);
  localparam int RP_C   = `AT_LEAST1(`CYC_UP(`T_RP_NS)); // RULE16
  localparam int RAS_C  = `AT_LEAST1(`CYC_UP(`T_RAS_NS)); // RULE16
  localparam int RCD_C  = `AT_LEAST1(`CYC_UP(`T_RCD_NS));
  localparam int RAH_C  = `AT_LEAST1(`CYC_UP(`T_RAH_NS));
  localparam int CP_C   = `AT_LEAST1(`CYC_UP(`T_CP_NS));
  localparam int PC_C   = `AT_LEAST1(`CYC_UP(`T_PC_NS));
  localparam int CSR_C  = `AT_LEAST1(`CYC_UP(`T_CSR_NS));
  localparam int CHR_C  = `AT_LEAST1(`CYC_UP(`T_CHR_NS));
  localparam int RHCP_C = `AT_LEAST1(`CYC_UP(`T_RHCP_NS));
  localparam int WR_C   = `MAX2(`MAX2(`CYC_UP(`T_WCH_NS), `CYC_UP(`T_WP_NS)), `CYC_UP(`T_DH_NS));
  localparam int RD_C   = `MAX2(`CYC_UP(`T_CAC_NS), `CYC_UP(`T_ACP_NS) - CP_C);
  localparam int COL_C  = `MAX2(`MAX2(PC_C - CP_C, WR_C), RD_C); // RULE16
  localparam int REF_C  = `AT_LEAST1(`CYC_DN((`T_REF_MS * `NS_PER_MS) / `REF_ROWS)); // RULE16
  localparam int PAGE_LIM = PAGE_MAX_CYC - (CP_C + COL_C + RHCP_C) - 1;

  dram_host_pkg::state_t state_reg, state_next;
  dram_host_pkg::req_t   cur_reg;
  dram_host_pkg::pins_t  pins_next;
  logic [`CNT_W-1:0]   cnt_reg, cnt_next;
  logic [`CNT_W-1:0]   page_cnt_reg;
  logic [`CNT_W-1:0]   ref_cnt_reg;
  logic                ref_pend_reg;
  logic [3:0]          init_cnt_reg;
  logic [`ADDR_W-1:0]  ror_row_reg;
  logic                rd_sample_reg;
  logic                done;
  logic                hit_ok;
  logic                accept;

  assign done   = (cnt_reg == '0);
  // a page hit keeps the row open only if refresh is not owed and the row limit is not near
  assign hit_ok = !ref_pend_reg && (req.row == cur_reg.row) &&
                  (page_cnt_reg < `CNT_W'(PAGE_LIM)); // RULE10
  assign req_ready = (state_reg == dram_host_pkg::ST_IDLE && init_done && !ref_pend_reg) ||
                     (state_reg == dram_host_pkg::ST_COL && done && hit_ok);
  assign accept = req_valid && req_ready;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = done ? cnt_reg : cnt_reg - `CNT_W'(1);
    case (state_reg)
      dram_host_pkg::ST_INIT:
        if (done)
        begin
          state_next = dram_host_pkg::ST_ROR; // RULE1
          cnt_next   = `CNT_W'(RAS_C - 1);
        end
      dram_host_pkg::ST_ROR, dram_host_pkg::ST_RHOLD, dram_host_pkg::ST_CBR_RAS:
        if (done)
        begin
          state_next = dram_host_pkg::ST_PRECH;
          cnt_next   = `CNT_W'(RP_C - 1);
        end
      dram_host_pkg::ST_PRECH:
        if (done)
          state_next = dram_host_pkg::ST_IDLE;
      dram_host_pkg::ST_IDLE:
        if (!init_done)
        begin
          state_next = dram_host_pkg::ST_ROR; // RULE1
          cnt_next   = `CNT_W'(RAS_C - 1);
        end
        else if (ref_pend_reg)
        begin
          state_next = dram_host_pkg::ST_CBR_SET; // RULE2
          cnt_next   = `CNT_W'(CSR_C - 1);
        end
        else if (accept)
        begin
          state_next = dram_host_pkg::ST_ROW;
          cnt_next   = `CNT_W'(RCD_C - 1);
        end
      dram_host_pkg::ST_ROW, dram_host_pkg::ST_CPRE:
        if (done)
        begin
          state_next = dram_host_pkg::ST_COL;
          cnt_next   = `CNT_W'(COL_C - 1);
        end
      dram_host_pkg::ST_COL:
        if (done && accept)
        begin
          state_next = dram_host_pkg::ST_CPRE; // RULE9
          cnt_next   = `CNT_W'(CP_C - 1);
        end
        else if (done)
        begin
          state_next = dram_host_pkg::ST_RHOLD; // RULE12
          cnt_next   = `CNT_W'(RHCP_C - 1);
        end
      dram_host_pkg::ST_CBR_SET:
        if (done)
        begin
          state_next = dram_host_pkg::ST_CBR_RAS; // RULE6
          cnt_next   = `CNT_W'(RAS_C - 1);
        end
      default:
      begin
        state_next = dram_host_pkg::ST_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= dram_host_pkg::ST_INIT;
      cnt_reg   <= `CNT_W'(INIT_CYC - 1);
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // current access, replaced on each accepted request
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cur_reg <= '0;
    else if (accept)
      cur_reg <= req;
  end

  // init row strobe cycles, row-only refresh addresses
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      init_cnt_reg <= '0;
      ror_row_reg  <= '0;
      init_done    <= 1'b0;
    end
    else
    begin
      if (state_reg == dram_host_pkg::ST_ROR && done)
      begin
        init_cnt_reg <= init_cnt_reg + 4'(1); // RULE1
        ror_row_reg  <= ror_row_reg + `ADDR_W'(1); // RULE15
      end
      init_done <= (init_cnt_reg == 4'(`INIT_CYCLES));
    end
  end

  // refresh timer; a tick in the clearing cycle keeps the request pending
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ref_cnt_reg  <= `CNT_W'(REF_C - 1);
      ref_pend_reg <= 1'b0;
    end
    else if (init_done)
    begin
      ref_cnt_reg <= (ref_cnt_reg == '0) ? `CNT_W'(REF_C - 1) : ref_cnt_reg - `CNT_W'(1); // RULE14
      if (ref_cnt_reg == '0)
        ref_pend_reg <= 1'b1; // RULE2
      else if (state_next == dram_host_pkg::ST_CBR_SET && state_reg == dram_host_pkg::ST_IDLE)
        ref_pend_reg <= 1'b0;
    end
  end

  // row-low time of the open page
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      page_cnt_reg <= '0;
    else if (state_reg inside {dram_host_pkg::ST_ROW, dram_host_pkg::ST_COL,
                               dram_host_pkg::ST_CPRE, dram_host_pkg::ST_RHOLD})
      page_cnt_reg <= page_cnt_reg + `CNT_W'(1); // RULE10
    else
      page_cnt_reg <= '0;
  end

  always_comb
  begin
    pins_next        = '0;
    pins_next.ras_n  = 1'b1;
    pins_next.cas_n  = '1;
    pins_next.we_n   = 1'b1;
    pins_next.addr   = cur_reg.row;
    pins_next.dq_out = cur_reg.wdata;
    case (state_reg)
      dram_host_pkg::ST_ROR:
      begin
        pins_next.ras_n = 1'b0; // RULE15
        pins_next.addr  = ror_row_reg;
      end
      dram_host_pkg::ST_ROW, dram_host_pkg::ST_COL, dram_host_pkg::ST_CPRE:
      begin
        pins_next.ras_n = 1'b0;
        pins_next.we_n  = !cur_reg.write; // RULE3 RULE5
        pins_next.dq_oe = cur_reg.write; // RULE4 RULE17
        if (state_reg != dram_host_pkg::ST_ROW || cnt_reg <= `CNT_W'(RCD_C - 1 - RAH_C))
          pins_next.addr = cur_reg.col; // RULE13
        if (state_reg == dram_host_pkg::ST_COL)
          pins_next.cas_n = cur_reg.write ? ~cur_reg.be : '0;
      end
      dram_host_pkg::ST_RHOLD:
      begin
        pins_next.ras_n = 1'b0; // RULE12
        pins_next.addr  = cur_reg.col;
      end
      dram_host_pkg::ST_CBR_SET:
        pins_next.cas_n = '0; // RULE6 RULE15
      dram_host_pkg::ST_CBR_RAS:
      begin
        pins_next.ras_n = 1'b0;
        pins_next.cas_n = (cnt_reg >= `CNT_W'(RHCP_C)) ? '0 : '1; // RULE6
      end
      default:
        pins_next.ras_n = 1'b1; // RULE7
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pins          <= '{ras_n: 1'b1, cas_n: '1, we_n: 1'b1, default: '0};
      rd_sample_reg <= 1'b0;
      rsp_valid     <= 1'b0;
      rsp_data      <= '0;
    end
    else
    begin
      pins          <= pins_next;
      rd_sample_reg <= (state_reg == dram_host_pkg::ST_COL) && done && !cur_reg.write;
      rsp_valid     <= rd_sample_reg;
      if (rd_sample_reg)
        rsp_data <= dq_in; // RULE11
    end
  end

  // helper counters watched only by the checks below
  logic cas_hi;
  int   since_rst;
  int   since_fall;
  int   hi_cnt;
  int   ras_falls;
  int   ref_age;
  assign cas_hi = &pins.cas_n;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      since_rst  <= 0;
      since_fall <= 0;
      hi_cnt     <= 0;
      ras_falls  <= 0;
      ref_age    <= 0;
    end
    else
    begin
      since_rst  <= (since_rst < INIT_CYC + 1) ? since_rst + 1 : since_rst;
      since_fall <= $fell(cas_hi) ? 1 : (since_fall < 1000) ? since_fall + 1 : since_fall;
      hi_cnt     <= !cas_hi ? 0 : (hi_cnt < 1000) ? hi_cnt + 1 : hi_cnt;
      ras_falls  <= ($fell(pins.ras_n) && ras_falls < 16) ? ras_falls + 1 : ras_falls;
      ref_age    <= (!init_done || state_reg == dram_host_pkg::ST_CBR_RAS) ? 0 : ref_age + 1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_cbr_lead;
    pins.cas_n == '0 && pins.ras_n ##1 pins.cas_n == '0 && pins.ras_n ##1 !pins.ras_n;
  endsequence
  sequence s_wr_edge;
    $rose(!cas_hi) && !pins.ras_n && pins.dq_oe;
  endsequence

  a_init_pause: assert property ($fell(pins.ras_n) |-> since_rst >= INIT_CYC) // RULE1
    else $error("row strobe before power-up pause");
  a_init_cycles: assert property (accept |-> ras_falls >= 8) // RULE1
    else $error("access before eight init cycles");
  a_early_write: assert property (s_wr_edge |-> !pins.we_n && !$past(pins.we_n)) // RULE3
    else $error("write strobe late for early write");
  a_data_hold: assert property (s_wr_edge |-> (pins.dq_oe && $stable(pins.dq_out))[*3]) // RULE4
    else $error("write data not held");
  a_we_hold: assert property (s_wr_edge |-> (!pins.we_n)[*3]) // RULE5
    else $error("write strobe released early");
  a_cbr_order: assert property (s_cbr_lead |-> (pins.cas_n == '0)[*2]) // RULE6
    else $error("column-before-row order broken");
  a_cbr_entry: assert property ($fell(cas_hi) && pins.ras_n |->
      $past(pins.ras_n) && $past(pins.ras_n, 2) && $past(cas_hi) && $past(cas_hi, 2)) // RULE7
    else $error("column strobe fell too soon after row strobe rose");
  a_page_cycle: assert property ($fell(cas_hi) && !pins.ras_n |-> since_fall >= PC_C) // RULE8
    else $error("page cycle too short");
  a_cas_prech: assert property ($rose(cas_hi) && !pins.ras_n |-> cas_hi[*2]) // RULE9
    else $error("page precharge too short");
  a_page_max: assert property (page_cnt_reg <= `CNT_W'(PAGE_MAX_CYC)) // RULE10
    else $error("row strobe low too long");
  a_row_hold: assert property ($rose(pins.ras_n) |-> hi_cnt >= RHCP_C) // RULE12
    else $error("row released too soon after precharge");
  a_ref_rate: assert property (ref_age <= REF_C + PAGE_MAX_CYC + 64) // RULE2 RULE14
    else $error("refresh overdue");
endmodule : dram_host
`default_nettype wire

// ===== verif/dram_module_model.sv
// behavioural dram module on the far side of the host controller
`timescale 1ns/1ns
`default_nettype none
`include "dram_host_consts.svh"
module dram_module_model #(
  parameter int RAS_MAX_NS = 100000,
  parameter int AA_NS      = 45
) (
  // strobes and address
  input  wire logic               ras_n,
  input  wire logic [`LANES-1:0]  cas_n,
  input  wire logic               we_n,
  input  wire logic [`ADDR_W-1:0] addr,
  // data lines
  input  wire logic [`DATA_W-1:0] dq,
  output logic [`DATA_W-1:0]      dq_drv,
  output logic                    dq_en,
  // counts for the bench
  output int                      viol,
  output int                      ras_cnt,
  output int                      cbr_cnt
);
  logic [`DATA_W-1:0] mem [bit [2*`ADDR_W-1:0]];
  logic [`ADDR_W-1:0] row_reg;
  logic               cbr;
  int                 seq;
  realtime            t_rf, t_rr, t_cf, t_cr, t_wf, t_ad, t_cbr, rd;
  wire logic          cas_lo = (cas_n != '1);

  initial
  begin
    t_rf = 0;
    t_rr = 0;
    t_cf = 0;
    t_cr = 0;
    t_wf = 0;
    t_ad = 0;
    t_cbr = 0;
    dq_drv = '0;
    dq_en = 1'b0;
  end

  task automatic flag(input string m);
    viol++;
    $display("unexpected at %0t: dram timing %s", $time, m);
  endtask : flag

  // data shows only after the slowest of the access paths
  task automatic drive(input int s, input realtime d, input logic [`DATA_W-1:0] v);
    #d;
    if (s == seq && cas_lo)
    begin
      dq_drv = v;
      dq_en = 1'b1;
    end
  endtask : drive

  task automatic hold_chk(input logic [`DATA_W-1:0] v);
    #(`T_DH_NS);
    if (dq !== v) flag("data hold");
  endtask : hold_chk

  always @(addr) t_ad = $realtime;
  always @(negedge we_n) t_wf = $realtime;

  always @(posedge we_n)
  begin
    if (t_cf > t_wf && $realtime - t_cf < `T_WCH_NS) flag("write hold");
    // the first rise out of reset follows no fall and is not a pulse
    if (t_wf > 0 && $realtime - t_wf < `T_WP_NS) flag("write pulse");
  end

  always @(negedge ras_n)
  begin
    t_rf = $realtime;
    ras_cnt++;
    cbr = cas_lo;
    if (!cas_lo)
      row_reg = addr;
    else
    begin
      cbr_cnt++;
      if ($realtime - t_cf < `T_CSR_NS) flag("cbr setup");
      // slack covers an access still in progress when refresh falls due
      if (cbr_cnt > 1 && $realtime - t_cbr > (`T_REF_MS * `NS_PER_MS) / `REF_ROWS + 400) flag("refresh gap");
      t_cbr = $realtime;
    end
  end

  always @(posedge ras_n)
  begin
    if ($realtime - t_rf > RAS_MAX_NS) flag("row pulse");
    if (!cbr && t_cr > t_rf && $realtime - t_cr < `T_RHCP_NS) flag("row hold");
    t_rr = $realtime;
  end

  always @(posedge cas_lo)
  begin
    seq++;
    if (ras_n && $realtime - t_rr < `T_RPC_NS) flag("cbr column");
    if (!ras_n && t_cf > t_rf)
    begin
      if ($realtime - t_cf < `T_PC_NS) flag("page cycle");
      if ($realtime - t_cr < `T_CP_NS) flag("column precharge");
    end
    t_cf = $realtime;
    if (!ras_n && !we_n)
    begin
      for (int i = 0; i < `LANES; i++)
        if (!cas_n[i]) mem[{row_reg, addr}][8*i +: 8] = dq[8*i +: 8];
      fork
        hold_chk(dq);
      join_none
    end
    else if (!ras_n)
    begin
      dq_drv = ~dq_drv;
      rd = `MAX2(`T_CAC_NS, t_ad + AA_NS - $realtime);
      if (t_cr > t_rf) rd = `MAX2(rd, t_cr + `T_ACP_NS - $realtime);
      fork
        drive(seq, rd, mem[{row_reg, addr}]);
      join_none
    end
  end

  always @(negedge cas_lo)
  begin
    t_cr = $realtime;
    if (cbr && !ras_n && $realtime - t_rf < `T_CHR_NS) flag("cbr hold");
    if (dq_en) dq_drv = ~dq_drv;
    dq_en = 1'b0;
  end
endmodule : dram_module_model
`default_nettype wire

// ===== verif/dram_host_tb.sv
// self-checking bench for the dram host controller
`timescale 1ns/1ns
`default_nettype none
`include "dram_host_consts.svh"
module dram_host_tb;
  localparam int INIT_N = 20;
  localparam int PAGE_N = 40;
  localparam int REF_N  = 1953;
  logic                 sys_clk, reset, req_valid, req_ready, rsp_valid, init_done, dq_en;
  dram_host_pkg::req_t  req;
  dram_host_pkg::pins_t pins;
  logic [`DATA_W-1:0]   rsp_data, dq_in, dq_drv;
  logic [`DATA_W-1:0]   shadow [bit [19:0]];
  logic [`DATA_W-1:0]   exp_q [$];
  int                   due_q [$];
  int                   viol, ras_cnt, cbr_cnt, n_fail, cmp_count, cyc, acc;

  assign dq_in = pins.dq_oe ? pins.dq_out : dq_drv;

  dram_host #(.INIT_CYC(INIT_N), .PAGE_MAX_CYC(PAGE_N)) dram_host_i (
    .sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done), .pins(pins), .dq_in(dq_in));

  dram_module_model #(.RAS_MAX_NS(PAGE_N * `T_CLK_NS)) dram_module_model_i (
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .addr(pins.addr), .dq(dq_in),
    .dq_drv(dq_drv), .dq_en(dq_en), .viol(viol), .ras_cnt(ras_cnt), .cbr_cnt(cbr_cnt));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // leaves the request valid so the next call can follow as a page hit
  task automatic send(input logic w, input logic [9:0] r, input logic [9:0] c, input logic [3:0] be,
                      input logic [31:0] d, input int lat);
    int n;
    n = 0;
    req <= '{write: w, row: r, col: c, be: be, wdata: d};
    req_valid <= 1'b1;
    @(negedge sys_clk);
    while (req_ready !== 1'b1)
    begin
      n++;
      if (n > 4000)
      begin
        check(n, 0, "request never taken");
        summarize();
      end
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    acc = cyc;
    for (int i = 0; i < `LANES; i++)
      if (w && be[i])
        shadow[{r, c}][8*i +: 8] = d[8*i +: 8];
    if (!w)
    begin
      exp_q.push_back(shadow[{r, c}]);
      due_q.push_back(acc + lat);
    end
  endtask : send

  task automatic drain;
    req_valid <= 1'b0;
    repeat (60) @(posedge sys_clk);
    check(exp_q.size(), 0, "missing read answer");
  endtask : drain

  always @(negedge sys_clk)
  begin
    check(dq_en & pins.dq_oe, 0, "data line contention");
    if (rsp_valid === 1'b1)
    begin
      check(exp_q.size() > 0, 1, "unrequested answer");
      if (exp_q.size() > 0)
      begin
        check(rsp_data, exp_q.pop_front(), "read data");
        check(cyc, due_q.pop_front(), "read latency");
      end
    end
  end

  task automatic t_init;
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(n >= INIT_N + 7 * 22 + 13 && n <= INIT_N + 8 * 22 + 4, 1, "init length");
    check(ras_cnt, 8, "init row cycles");
    check(cbr_cnt, 0, "refresh during init");
    if (n >= 1000)
      summarize();
    @(posedge sys_clk);
  endtask : t_init

  task automatic t_lanes;
    send(1, 10'h005, 10'h009, 4'hf, 32'h1234_5678, 0);
    send(1, 10'h005, 10'h009, 4'h5, 32'haaaa_5555, 0);
    send(0, 10'h005, 10'h009, 4'hf, 32'h0000_0000, 9);
    send(1, 10'h006, 10'h001, 4'hf, 32'h0bad_f00d, 0);
    send(0, 10'h005, 10'h009, 4'hf, 32'h0000_0000, 11);
    drain();
  endtask : t_lanes

  task automatic t_page;
    int a;
    a = 0;
    for (int i = 0; i < 4; i++)
    begin
      send(i < 2, 10'h003, 10'(i % 2), 4'hf, 32'h0303_0000 + 32'(i), (i < 2) ? 0 : 9);
      // the first hit follows row open plus one column, later hits one precharge plus one column
      if (i > 0) check(acc - a, (i == 1) ? 9 : 7, "page spacing");
      a = acc;
    end
    drain();
    // a burst longer than the page limit forces a close and reopen
    for (int i = 0; i < 12; i++)
      send(1, 10'h004, 10'(i), 4'hf, 32'h0404_0000 + 32'(i), 0);
    drain();
    send(0, 10'h004, 10'h00b, 4'hf, 32'h0000_0000, 11);
    send(0, 10'h004, 10'h000, 4'hf, 32'h0000_0000, 9);
    drain();
  endtask : t_page

  task automatic t_refresh;
    req_valid <= 1'b0;
    repeat (2 * REF_N) @(posedge sys_clk);
    check(cbr_cnt >= cyc / REF_N - 1 && cbr_cnt <= cyc / REF_N, 1, "refresh count");
    check(viol, 0, "dram timing");
  endtask : t_refresh

  initial
  begin
    req_valid = 1'b0;
    req = '0;
    reset = 1'b1;
    repeat (5) @(posedge sys_clk);
    check({pins.ras_n, pins.cas_n, pins.we_n, pins.dq_oe, req_ready, init_done}, 9'h1f8, "reset pins");
    reset <= 1'b0;
    t_init();
    t_lanes();
    t_page();
    t_refresh();
    summarize();
  end
endmodule : dram_host_tb
`default_nettype wire
